// ==== rtl/adc_ctrl_pkg.sv ====
// Purpose: Types of the converter control block.
// Assumes: Included constants header.
// Notes:   One-hot state codes.
package adc_ctrl_pkg;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_ARMED = 4'b0010,
        ST_CONV  = 4'b0100,
        ST_DONE  = 4'b1000
    } conv_state_e;
endpackage

// ==== rtl/adc_ctrl_regs.svh ====
// Purpose: Timing counts and field sizes of the converter control block.
// Assumes: 100 MHz system clock.
// Notes:   Definitions only.
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

`define CLK_PERIOD_NS      10
`define CHAN_BITS          4
`define RESULT_BITS        8
// Conversion clock periods per conversion: 108 us typical at 640 kHz gives 69.
`define CONV_CLOCKS        69
// One conversion clock period at 640 kHz is 1562.5 ns; shortest count rounds down.
`define CONV_PERIOD_NS     1562
`define CONV_DIV_CYCLES    (`CONV_PERIOD_NS / `CLK_PERIOD_NS)
// On-chip oscillator is taken as the same nominal 640 kHz.
`define OSC_DIV_CYCLES     (`CONV_PERIOD_NS / `CLK_PERIOD_NS)
// External clock is declared absent after this many nanoseconds with no edge.
`define EXT_CLK_LOSS_NS    20000
`define EXT_CLK_LOSS_CYC   (`EXT_CLK_LOSS_NS / `CLK_PERIOD_NS)
`define EOC_START_CLOCKS   1

`endif

// ==== rtl/approx_core.sv ====
// Purpose: Successive-approximation register deciding one bit per step.
// Assumes: Comparator result valid when a step is taken.
// Notes:   MSB first.
`timescale 1ns/1ns
`default_nettype none
module approx_core
    import adc_ctrl_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // Clock and reset.
    input  wire logic clock_i,
    input  wire logic rst_i,
    // Step channel.
    sar_step_if.core  sif
);
    logic [WIDTH-1:0] approx_register_q, approx_register_d;
    logic [WIDTH-1:0] trial_q, trial_d;

    // =========================================================
    // Bit decision
    always_comb begin
        approx_register_d = approx_register_q;
        trial_d           = trial_q;
        if (sif.clear) begin
            approx_register_d = {1'b1, {(WIDTH-1){1'b0}}};
            trial_d           = {1'b1, {(WIDTH-1){1'b0}}};
        end else if (sif.step && trial_q != '0) begin
            // Keep the trial bit only when the input is above the trial level.
            if (!sif.cmp) begin
                approx_register_d = approx_register_q & ~trial_q;
            end
            approx_register_d = approx_register_d | (trial_q >> 1);
            trial_d           = trial_q >> 1;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            approx_register_q <= '0;
            trial_q           <= '0;
        end else begin
            approx_register_q <= approx_register_d;
            trial_q           <= trial_d;
        end
    end

    assign sif.value = approx_register_q[7:0];
    assign sif.last  = (trial_q == {{(WIDTH-1){1'b0}}, 1'b1});

    chk_one_hot_trial: assert property (@(posedge clock_i) disable iff (rst_i)
        $onehot0(trial_q)) else $error("trial bit not one-hot");
    chk_clear_msb: assert property (@(posedge clock_i) disable iff (rst_i)
        sif.clear |=> approx_register_q == {1'b1, {(WIDTH-1){1'b0}}}) else $error("clear did not seed msb");
endmodule
`default_nettype wire

// ==== rtl/sar_adc_mux_control.sv ====
// Purpose: Control of an 8-bit successive-approximation converter with 16-way input select.
// Assumes: All inputs synchronous to clock_i; comparator result arrives as a level.
// Notes:   Conversion clock comes from the external clock pin or an on-chip divider.
// Functional notes
// - Strobe rising edge latches four select bits.
// - Expansion high: exactly one of sixteen enabled.
// - Expansion low disables every internal channel.
// - Conversion takes 106 to 110 us.
// - Fed-back start drops end flag one period.
// - End flag as start runs continuously.
// - External clock used; grounded pin uses oscillator.
// - Start pulse begins; end flag marks finish.
// - Eight bits decided MSB first.
// - Result held in latch until next finish.
// - Start rise clears; fall begins; restart aborts.
// - End flag low within two conversion periods.
// - Output enable low floats result pins.
`timescale 1ns/1ns
`default_nettype none
`include "adc_ctrl_regs.svh"
module sar_adc_mux_control
    import adc_ctrl_pkg::*;
#(
    parameter int CHANNELS   = 16,
    parameter int CONV_STEPS = `CONV_CLOCKS
) (
    // Clock and reset.
    input  wire logic                     clock_i,
    input  wire logic                     rst_i,
    // Channel select.
    input  wire logic [`CHAN_BITS-1:0]    chan_sel_i,
    input  wire logic                     addr_strobe_i,
    input  wire logic                     expand_en_i,
    output logic      [CHANNELS-1:0]      chan_en_o,
    // Conversion control.
    input  wire logic                     start_i,
    input  wire logic                     conv_clk_i,
    input  wire logic                     cmp_above_i,
    output logic                          eoc_o,
    output logic                          use_osc_o,
    output logic                          conv_tick_o,
    // Result pins.
    input  wire logic                     out_en_i,
    output logic      [`RESULT_BITS-1:0]  data_o,
    output logic      [`RESULT_BITS-1:0]  data_oe_n_o
);
    sar_step_if sif ();

    conv_state_e      state_q, state_d;
    logic [3:0]       chan_q, chan_d;
    logic             strobe_q, start_q, ext_q;
    logic [15:0]      loss_q, loss_d;
    logic [15:0]      div_q, div_d;
    logic [7:0]       steps_q, steps_d;
    logic [7:0]       result_q, result_d;
    logic             eoc_q, eoc_d;
    logic             tick;
    logic             use_osc;

    function automatic logic [CHANNELS-1:0] decode_chan(input logic [3:0] code, input logic en);
        decode_chan = '0;
        if (en) begin
            decode_chan[code] = 1'b1;
        end
    endfunction

    // =========================================================
    // Address latch and decode
    always_comb begin
        chan_d = chan_q;
        if (addr_strobe_i && !strobe_q) begin
            chan_d = chan_sel_i;
        end
    end
    // Only expansion high enables a channel; low leaves all off.
    assign chan_en_o = decode_chan(chan_q, expand_en_i);

    // =========================================================
    // Conversion clock source
    // Any edge on the external pin restarts the loss timer; silence selects the oscillator.
    always_comb begin
        loss_d = loss_q;
        if (conv_clk_i != ext_q) begin
            loss_d = '0;
        end else if (loss_q != 16'(`EXT_CLK_LOSS_CYC)) begin
            loss_d = loss_q + 16'd1;
        end
        div_d = (div_q >= 16'(`OSC_DIV_CYCLES - 1)) ? 16'd0 : div_q + 16'd1;
    end
    assign use_osc = (loss_q == 16'(`EXT_CLK_LOSS_CYC));
    assign tick    = use_osc ? (div_q == 16'd0) : (conv_clk_i && !ext_q);

    // =========================================================
    // Conversion sequence
    always_comb begin
        state_d  = state_q;
        steps_d  = steps_q;
        result_d = result_q;
        eoc_d    = eoc_q;
        sif.clear = 1'b0;
        sif.step  = 1'b0;
        sif.cmp   = cmp_above_i;
        if (start_i && !start_q) begin
            // A new start always wins, abandoning any conversion.
            state_d   = ST_ARMED;
            sif.clear = 1'b1;
            steps_d   = '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    state_d = ST_IDLE;
                end
                ST_ARMED: begin
                    if (tick) begin
                        eoc_d = 1'b0;
                    end
                    if (!start_i) begin
                        state_d = ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (tick) begin
                        eoc_d   = 1'b0;
                        steps_d = steps_q + 8'd1;
                        sif.step = (steps_q[2:0] == 3'd7) && (steps_q < 8'd64);
                        if (steps_q == 8'(CONV_STEPS - 1)) begin
                            state_d = ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    result_d = sif.value;
                    eoc_d    = 1'b1;
                    state_d  = ST_IDLE;
                end
                default: state_d = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_q  <= ST_IDLE;
            chan_q   <= '0;
            strobe_q <= 1'b0;
            start_q  <= 1'b0;
            ext_q    <= 1'b0;
            loss_q   <= '0;
            div_q    <= '0;
            steps_q  <= '0;
            result_q <= '0;
            eoc_q    <= 1'b0;
        end else begin
            state_q  <= state_d;
            chan_q   <= chan_d;
            strobe_q <= addr_strobe_i;
            start_q  <= start_i;
            ext_q    <= conv_clk_i;
            loss_q   <= loss_d;
            div_q    <= div_d;
            steps_q  <= steps_d;
            result_q <= result_d;
            eoc_q    <= eoc_d;
        end
    end

    approx_core #(
        .WIDTH (`RESULT_BITS)
    ) u_core (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .sif     (sif)
    );

    // =========================================================
    // Outputs
    assign eoc_o       = eoc_q;
    assign use_osc_o   = use_osc;
    assign conv_tick_o = tick;
    assign data_o      = result_q;
    // Low enable floats the pins; the enable output data_oe_n_o is active low.
    assign data_oe_n_o = {`RESULT_BITS{~out_en_i}};

    // =========================================================
    // Checks
    chk_strobe_latch: assert property (@(posedge clock_i) disable iff (rst_i)
        (addr_strobe_i && !strobe_q) |=> chan_q == $past(chan_sel_i)) else $error("select not latched");
    chk_chan_hold: assert property (@(posedge clock_i) disable iff (rst_i)
        !(addr_strobe_i && !strobe_q) |=> $stable(chan_q)) else $error("select changed without strobe");
    chk_one_chan: assert property (@(posedge clock_i) disable iff (rst_i)
        expand_en_i |-> (chan_en_o == (16'd1 << chan_q))) else $error("wrong channel enabled");
    chk_expand_off: assert property (@(posedge clock_i) disable iff (rst_i)
        !expand_en_i |-> chan_en_o == '0) else $error("channel on while expansion low");
    chk_result_hold: assert property (@(posedge clock_i) disable iff (rst_i)
        state_q != ST_DONE |=> $stable(data_o)) else $error("result changed mid-conversion");
    chk_eoc_rise: assert property (@(posedge clock_i) disable iff (rst_i)
        $rose(eoc_o) |-> $past(state_q) == ST_DONE) else $error("end flag rose early");
    chk_restart: assert property (@(posedge clock_i) disable iff (rst_i)
        (start_i && !start_q) |=> state_q == ST_ARMED) else $error("start did not restart");
    chk_oe_follow: assert property (@(posedge clock_i) disable iff (rst_i)
        data_oe_n_o == {8{~out_en_i}}) else $error("output enable wrong");
    chk_step_count: assert property (@(posedge clock_i) disable iff (rst_i)
        state_q == ST_DONE |-> steps_q == 8'(CONV_STEPS)) else $error("conversion length wrong");
    // The eighth decision must fall on the last trial bit, or the lowest bit would go undecided.
    chk_last_step: assert property (@(posedge clock_i) disable iff (rst_i)
        (sif.step && steps_q == 8'd63) |-> sif.last) else $error("last decision missed the lsb");
    // Dropping the end flag on the first tick keeps it inside one conversion period.
    chk_eoc_drop: assert property (@(posedge clock_i) disable iff (rst_i)
        (state_q == ST_ARMED && tick && !(start_i && !start_q)) |=> !eoc_o)
        else $error("end flag held after start");
    cov_convert: cover property (@(posedge clock_i) disable iff (rst_i) $rose(eoc_o));
    // A rising end flag fed back as start re-arms on the next sample.
    cov_free_run: cover property (@(posedge clock_i) disable iff (rst_i)
        $rose(eoc_o) ##1 state_q == ST_ARMED);
    cov_expand_off: cover property (@(posedge clock_i) disable iff (rst_i) !expand_en_i && chan_en_o == '0);
    cov_abort: cover property (@(posedge clock_i) disable iff (rst_i)
        state_q == ST_CONV && start_i && !start_q);
    cov_osc: cover property (@(posedge clock_i) disable iff (rst_i) $rose(use_osc));
endmodule
`default_nettype wire

// ==== rtl/sar_step_if.sv ====
// Purpose: Carries the step handshake between control and the approximation core.
// Assumes: Single clock.
// Notes:   None.
`timescale 1ns/1ns
`default_nettype none
interface sar_step_if;
    logic       clear;
    logic       step;
    logic       cmp;
    logic       last;
    logic [7:0] value;
    modport ctrl (output clear, output step, output cmp, input last, input value);
    modport core (input clear, input step, input cmp, output last, output value);
endinterface
`default_nettype wire

// ==== verification/host_model.sv ====
// Purpose: Host side model: conversion clock and comparator.
// Assumes: The comparator follows one target code, eight ticks per bit.
// Notes:   Bit windows count from the falling edge of start, MSB first.
`timescale 1ns/1ns
`default_nettype none
module host_model (
    // Clock.
    input  wire logic       clock_i,
    // Control.
    input  wire logic       run_i,
    input  wire logic       tick_i,
    input  wire logic       start_i,
    input  wire logic [7:0] target_i,
    // Outputs.
    output logic            conv_clk_o,
    output logic            cmp_above_o
);
    // ==========================================================
    // Clock and comparator
    int   div     = 0;
    int   n       = 99;
    logic start_q = 1'h0;
    logic clk_q   = 1'h0;
    // A grounded clock pin stays low while the clock is off.
    always @(posedge clock_i) begin
        start_q <= start_i;
        div <= (div == 77) ? 0 : div + 1;
        if (!run_i) clk_q <= 1'h0;
        else if (div == 77) clk_q <= ~clk_q;
        if (start_q && !start_i) n <= 0;
        else if (tick_i) n <= n + 1;
    end
    // Outside the decision windows the line toggles, so no result can lean on it.
    assign cmp_above_o = (n < 64) ? target_i[7 - n / 8] : div[0];
    assign conv_clk_o  = clk_q;
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// Purpose: Self-checking bench of the converter control block.
// Assumes: Inputs change at the falling clock edge.
// Notes:   Default conversion counts; a run is about 49000 cycles.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    // ==========================================================
    // Signals
    logic        clock_i = 1'h0;
    logic        rst_i   = 1'h1;
    logic [3:0]  chan_sel_i = 4'h0;
    logic        addr_strobe_i = 1'h0;
    logic        expand_en_i = 1'h1;
    logic        start_drv = 1'h0;
    logic        free_run = 1'h0;
    logic        run = 1'h1;
    logic        out_en_i = 1'h0;
    logic [7:0]  target = 8'hf0;
    logic        start_i;
    logic        conv_clk_i;
    logic        cmp_above_i;
    logic        eoc_o;
    logic        use_osc_o;
    logic        conv_tick_o;
    logic [15:0] chan_en_o;
    logic [7:0]  data_o;
    logic [7:0]  data_oe_n_o;
    int          fails = 0;
    int          checks_done = 0;
    int          cyc = 0;
    assign start_i = free_run ? eoc_o : start_drv;
    always #5 clock_i = ~clock_i;
    sar_adc_mux_control i_dut (.clock_i(clock_i), .rst_i(rst_i), .chan_sel_i(chan_sel_i),
        .addr_strobe_i(addr_strobe_i), .expand_en_i(expand_en_i), .chan_en_o(chan_en_o),
        .start_i(start_i), .conv_clk_i(conv_clk_i), .cmp_above_i(cmp_above_i), .eoc_o(eoc_o),
        .use_osc_o(use_osc_o), .conv_tick_o(conv_tick_o), .out_en_i(out_en_i),
        .data_o(data_o), .data_oe_n_o(data_oe_n_o));
    host_model i_host (.clock_i(clock_i), .run_i(run), .tick_i(conv_tick_o), .start_i(start_i),
        .target_i(target), .conv_clk_o(conv_clk_i), .cmp_above_o(cmp_above_i));
    // ==========================================================
    // Shared tasks
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_eoc(input logic lvl, input int lim, output int n);
        n = 0;
        while (eoc_o !== lvl && n < lim) begin
            @(negedge clock_i);
            n++;
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_mux();
        for (int c = 0; c < 16; c++) begin
            @(negedge clock_i);
            chan_sel_i = c[3:0];
            @(negedge clock_i);
            addr_strobe_i = 1'h1;
            @(negedge clock_i);
            addr_strobe_i = 1'h0;
            chan_sel_i = ~c[3:0];
            @(negedge clock_i);
            chk("chan_en", 16'h1 << c, chan_en_o);
        end
        expand_en_i = 1'h0;
        @(negedge clock_i);
        chk("chan_off", 16'h0, chan_en_o);
        expand_en_i = 1'h1;
        $display("t_mux done");
    endtask
    task automatic t_conv(input logic [7:0] val);
        int n;
        target = val;
        chan_sel_i = val[3:0];
        @(negedge clock_i);
        // Strobe tied to start: the first decision comes many conversion periods later, past the settle time.
        start_drv = 1'h1;
        addr_strobe_i = 1'h1;
        repeat (25) @(negedge clock_i);
        start_drv = 1'h0;
        addr_strobe_i = 1'h0;
        chk("tied_sel", 16'h1 << val[3:0], chan_en_o);
        wait_eoc(1'h1, 12000, n);
        chk("conv_time", 16'h1, 16'(n >= 10600 && n <= 11000));
        chk("result", val, data_o);
        out_en_i = 1'h1;
        @(negedge clock_i);
        chk("drive_en", 8'h00, data_oe_n_o);
        out_en_i = 1'h0;
        @(negedge clock_i);
        chk("float_en", 8'hff, data_oe_n_o);
        chk("osc_sel", 16'h0, use_osc_o);
        $display("t_conv done");
    endtask
    task automatic t_abort();
        int n;
        @(negedge clock_i);
        start_drv = 1'h1;
        wait_eoc(1'h0, 400, n);
        chk("eoc_drop", 16'h1, 16'(n <= 312));
        repeat (25) @(negedge clock_i);
        start_drv = 1'h0;
        target = 8'h0f;
        repeat (3000) @(negedge clock_i);
        chk("held", 8'hf0, data_o);
        t_conv(8'h3c);
        $display("t_abort done");
    endtask
    task automatic t_free();
        int n;
        target = 8'h0f;
        free_run = 1'h1;
        for (int k = 0; k < 2; k++) begin
            wait_eoc(1'h0, 400, n);
            chk("free_drop", 16'h1, 16'(n <= 160));
            wait_eoc(1'h1, 12000, n);
            chk("free_time", 16'h1, 16'(n >= 10600 && n <= 11000));
            chk("free_data", 8'h0f, data_o);
        end
        free_run = 1'h0;
        $display("t_free done");
    endtask
    task automatic t_osc();
        int n;
        run = 1'h0;
        repeat (2100) @(negedge clock_i);
        chk("osc_on", 16'h1, use_osc_o);
        n = 0;
        repeat (400) begin
            @(negedge clock_i);
            n += int'(conv_tick_o === 1'h1);
        end
        chk("osc_ticks", 16'h1, 16'(n >= 2 && n <= 3));
        $display("t_osc done");
    endtask
    // ==========================================================
    // Sequence and hang limit
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 90000) begin
            fails++;
            end_of_test();
        end
    end
    initial begin
        repeat (3) @(negedge clock_i);
        rst_i = 1'h0;
        @(negedge clock_i);
        chk("rst_eoc", 16'h0, eoc_o);
        chk("rst_data", 16'h0, data_o);
        t_mux();
        t_conv(8'hf0);
        t_abort();
        t_free();
        t_osc();
        end_of_test();
    end
endmodule
`default_nettype wire
